// ### verilog/pcs_pkg.sv
// Constants and carrier types for the protection configuration switch groups.
// Assumes one 25 MHz system clock, a synchronous active-high reset and an
// AHB-Lite master that issues single word transfers only.
package pcs_pkg;

  localparam int NUM_STAGES = 7;
  localparam int NUM_LEDS   = 8;
  localparam int NUM_PHASES = 3;
  localparam int NUM_GROUPS = 4;

  // Stage order of the indication group.
  localparam int STG_LOW_OC   = 0;
  localparam int STG_HIGH_OC  = 1;
  localparam int STG_VHIGH_OC = 2;
  localparam int STG_LOW_EF   = 3;
  localparam int STG_HIGH_EF  = 4;
  localparam int STG_DISC     = 5;
  localparam int STG_THERMAL  = 6;

  // Stages whose starting phases are reported in latching mode.
  localparam logic [6:0] PHASE_REPORT_MASK = 7'h55;

  // Field positions of the inhibit group.
  localparam int INH_HIGH_OC  = 0;
  localparam int INH_VHIGH_OC = 1;
  localparam int INH_HIGH_EF  = 2;
  localparam int INH_DISC     = 3;
  localparam int INH_THERMAL  = 4;
  localparam int INH_ARC      = 5;
  localparam int INH_LIGHT    = 6;

  // Field positions of the interaction option group.
  localparam int OPT_DBL_HIGH_OC   = 0;
  localparam int OPT_HOC_BLK_INV   = 1;
  localparam int OPT_VHOC_BLK_INV  = 2;
  localparam int OPT_DBL_HIGH_EF   = 3;
  localparam int OPT_HEF_BLK_INV   = 4;
  localparam int OPT_ARC_BLK_LIGHT = 5;

  // Reset values.
  localparam logic [6:0] MODE_RST = 7'h00;
  localparam logic [6:0] INH_RST  = 7'h78;
  localparam logic [5:0] OPT_RST  = 6'h00;
  localparam logic [7:0] LED_RST  = 8'h00;
  localparam logic [7:0] CHK_RST [NUM_GROUPS] = '{8'h00, 8'h78, 8'h00, 8'h00};

  // Byte addresses of the registers.
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_INH    = 8'h04;
  localparam logic [7:0] ADDR_OPT    = 8'h08;
  localparam logic [7:0] ADDR_LED    = 8'h0C;
  localparam logic [7:0] ADDR_CHK    = 8'h10;
  localparam logic [7:0] ADDR_CTRL   = 8'h20;
  localparam logic [7:0] ADDR_STATE  = 8'h24;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h2C;
  localparam logic [7:0] ADDR_PHASE  = 8'h30;

  // Control and interrupt fields.
  localparam int CTRL_CLEAR    = 0;
  localparam int NUM_EVENTS    = 4;
  localparam int EV_START      = 0;
  localparam int EV_LIGHT      = 1;
  localparam int EV_CHK_BAD    = 2;
  localparam int EV_CLEARED    = 3;

  // Field positions of the state register.
  localparam int ST_IND_LSB    = 0;
  localparam int ST_LED_LSB    = 8;
  localparam int ST_LIGHT      = 16;
  localparam int ST_CHK_OK_LSB = 20;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [6:0]      stage_start;
    logic [6:0][2:0] stage_phase;
    logic            inrush;
    logic            arc_trip;
    logic            light_request;
    logic [7:0]      led_signal;
    logic            front_panel_clear;
    logic            serial_clear;
  } pcs_prot_in_type;

  typedef struct packed {
    logic [6:0]      indication;
    logic [6:0][2:0] phase_display;
    logic [7:0]      programmable_indicator;
    logic [5:0]      stage_inhibit;
    logic            light_out;
    logic            double_high_oc;
    logic            double_high_ef;
    logic            block_low_oc_inverse;
    logic            block_low_ef_inverse;
  } pcs_prot_out_type;

endpackage : pcs_pkg

// ### verilog/pcs_switchgroups.sv
// Switch group registers with the indication, LED and light output logic.
// Protection inputs come from logic on the same clock; only the digital
// clear input arrives from a pin and is synchronised here.
`timescale 1ns/1ps
module pcs_switchgroups (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Protection side
  input  wire pcs_pkg::pcs_prot_in_type  prot_in,
  input  wire logic                  digital_clear_pin,
  output pcs_pkg::pcs_prot_out_type  prot_out,
  // Interrupt
  output logic                       irq
);

  typedef struct packed {
    logic [6:0]       mode;
    logic [6:0]       inhibit;
    logic [5:0]       options;
    logic [7:0]       led_latch;
    logic [3:0][7:0]  checksum;
    logic [3:0]       irq_status;
    logic [3:0]       irq_mask;
    logic             sw_clear;
    logic [1:0]       di_sync;
    logic             wr_pend;
    logic             rd_pend;
    logic [7:0]       addr;
    logic [31:0]      rdata;
    logic             ready;
    logic             resp;
    logic             irq;
    logic [3:0]       chk_ok;
    pcs_pkg::pcs_prot_out_type out;
  } pcs_state_type;

  pcs_state_type st_reg;
  pcs_state_type st_next;

  // Weighted switch sum: switch k (from 1) contributes 2**(k-1).
  function automatic logic [7:0] pcs_weighted_sum(input logic [7:0] sw);
    logic [7:0] acc;
    acc = 8'h00;
    for (int k = 0; k < 8; k++) begin
      if (sw[k]) begin
        acc = acc + (8'h01 << k);
      end
    end
    return acc;
  endfunction : pcs_weighted_sum

  function automatic logic [31:0] pcs_read(input pcs_state_type s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      pcs_pkg::ADDR_MODE:        d[6:0] = s.mode;
      pcs_pkg::ADDR_INH:         d[6:0] = s.inhibit;
      pcs_pkg::ADDR_OPT:         d[5:0] = s.options;
      pcs_pkg::ADDR_LED:         d[7:0] = s.led_latch;
      pcs_pkg::ADDR_CHK:         d[7:0] = s.checksum[0];
      pcs_pkg::ADDR_CHK + 8'h04: d[7:0] = s.checksum[1];
      pcs_pkg::ADDR_CHK + 8'h08: d[7:0] = s.checksum[2];
      pcs_pkg::ADDR_CHK + 8'h0C: d[7:0] = s.checksum[3];
      pcs_pkg::ADDR_STATE: begin
        d[pcs_pkg::ST_IND_LSB +: 7]    = s.out.indication;
        d[pcs_pkg::ST_LED_LSB +: 8]    = s.out.programmable_indicator;
        d[pcs_pkg::ST_LIGHT]           = s.out.light_out;
        d[pcs_pkg::ST_CHK_OK_LSB +: 4] = s.chk_ok;
      end
      pcs_pkg::ADDR_IRQ_ST:      d[3:0] = s.irq_status;
      pcs_pkg::ADDR_IRQ_MK:      d[3:0] = s.irq_mask;
      pcs_pkg::ADDR_PHASE:       d[20:0] = s.out.phase_display;
      default:                   d = 32'h0000_0000;
    endcase
    return d;
  endfunction : pcs_read

  always_comb begin
    logic [6:0]      start_eff;
    logic [6:0]      stage_off;
    logic            clear_req;
    logic            light_blk;
    logic [3:0]      events;
    logic [3:0]      w1c;
    logic [7:0]      sums [4];
    logic            take;
    st_next   = st_reg;
    start_eff = 7'h00;
    stage_off = 7'h00;
    clear_req = 1'b0;
    light_blk = 1'b0;
    events    = 4'h0;
    sums      = '{default: 8'h00};
    take      = 1'b0;
    w1c       = 4'h0;
    st_next.sw_clear = 1'b0;

    // Pin input passes two flip-flops; only the second is read below.
    st_next.di_sync = {st_reg.di_sync[0], digital_clear_pin};

    // Bus data phase of a write: stored at this edge, effective next cycle.
    if (st_reg.wr_pend) begin
      unique case (st_reg.addr)
        pcs_pkg::ADDR_MODE:        st_next.mode      = hwdata[6:0];
        pcs_pkg::ADDR_INH:         st_next.inhibit   = hwdata[6:0];
        pcs_pkg::ADDR_OPT:         st_next.options   = hwdata[5:0];
        pcs_pkg::ADDR_LED:         st_next.led_latch = hwdata[7:0];
        pcs_pkg::ADDR_CHK:         st_next.checksum[0] = hwdata[7:0];
        pcs_pkg::ADDR_CHK + 8'h04: st_next.checksum[1] = hwdata[7:0];
        pcs_pkg::ADDR_CHK + 8'h08: st_next.checksum[2] = hwdata[7:0];
        pcs_pkg::ADDR_CHK + 8'h0C: st_next.checksum[3] = hwdata[7:0];
        pcs_pkg::ADDR_CTRL:        st_next.sw_clear  = hwdata[pcs_pkg::CTRL_CLEAR];
        pcs_pkg::ADDR_IRQ_ST:      w1c = hwdata[3:0];
        pcs_pkg::ADDR_IRQ_MK:      st_next.irq_mask  = hwdata[3:0];
        default: ;
      endcase
    end

    // Address phase. Reads take one wait state so that the data reflect
    // a write whose data phase overlaps this address phase.
    take = hsel && hready && (htrans == pcs_pkg::HTRANS_NONSEQ);
    st_next.wr_pend = take && hwrite;
    st_next.rd_pend = take && !hwrite;
    st_next.ready   = !(take && !hwrite);
    if (take) begin
      st_next.addr = haddr[7:0];
    end
    if (st_reg.rd_pend) begin
      st_next.rdata = pcs_read(st_reg, st_reg.addr);
    end

    // Any of the clear sources serves all latched indications and LEDs.
    clear_req = prot_in.front_panel_clear | prot_in.serial_clear
              | st_reg.di_sync[1] | st_reg.sw_clear;

    // Starts of inhibited stages are ignored.
    stage_off = 7'h00;
    stage_off[pcs_pkg::STG_HIGH_OC]  = st_reg.inhibit[pcs_pkg::INH_HIGH_OC];
    stage_off[pcs_pkg::STG_VHIGH_OC] = st_reg.inhibit[pcs_pkg::INH_VHIGH_OC];
    stage_off[pcs_pkg::STG_HIGH_EF]  = st_reg.inhibit[pcs_pkg::INH_HIGH_EF];
    stage_off[pcs_pkg::STG_DISC]     = st_reg.inhibit[pcs_pkg::INH_DISC];
    stage_off[pcs_pkg::STG_THERMAL]  = st_reg.inhibit[pcs_pkg::INH_THERMAL];
    start_eff = prot_in.stage_start & ~stage_off;
    st_next.out.stage_inhibit = st_reg.inhibit[5:0];

    // A live start always wins over a clear in the same cycle.
    st_next.out.indication = start_eff
      | (st_reg.mode & st_reg.out.indication & {7{!clear_req}});

    for (int i = 0; i < pcs_pkg::NUM_STAGES; i++) begin
      if (st_reg.mode[i] && pcs_pkg::PHASE_REPORT_MASK[i]) begin
        st_next.out.phase_display[i] =
          (clear_req ? 3'h0 : st_reg.out.phase_display[i])
          | (start_eff[i] ? prot_in.stage_phase[i] : 3'h0);
      end else begin
        st_next.out.phase_display[i] = 3'h0;
      end
    end

    st_next.out.programmable_indicator = prot_in.led_signal
      | (st_reg.led_latch & st_reg.out.programmable_indicator
         & {8{!clear_req}});

    // Inrush doubling follows the live inrush input; inverse-time blocking follows the live starts.
    st_next.out.double_high_oc = prot_in.inrush
      & st_reg.options[pcs_pkg::OPT_DBL_HIGH_OC];
    st_next.out.double_high_ef = prot_in.inrush
      & st_reg.options[pcs_pkg::OPT_DBL_HIGH_EF];
    st_next.out.block_low_oc_inverse =
      (st_reg.options[pcs_pkg::OPT_HOC_BLK_INV] & start_eff[pcs_pkg::STG_HIGH_OC])
      | (st_reg.options[pcs_pkg::OPT_VHOC_BLK_INV] & start_eff[pcs_pkg::STG_VHIGH_OC]);
    st_next.out.block_low_ef_inverse =
      st_reg.options[pcs_pkg::OPT_HEF_BLK_INV] & start_eff[pcs_pkg::STG_HIGH_EF];

    // An inhibited arc stage cannot trip, so it cannot block the light output.
    light_blk = st_reg.options[pcs_pkg::OPT_ARC_BLK_LIGHT]
      & prot_in.arc_trip & !st_reg.inhibit[pcs_pkg::INH_ARC];
    st_next.out.light_out = prot_in.light_request & !light_blk
      & !st_reg.inhibit[pcs_pkg::INH_LIGHT];

    // Group validity against the stored checksums.
    sums[0] = pcs_weighted_sum({1'b0, st_reg.mode});
    sums[1] = pcs_weighted_sum({1'b0, st_reg.inhibit});
    sums[2] = pcs_weighted_sum({2'b00, st_reg.options});
    sums[3] = pcs_weighted_sum(st_reg.led_latch);
    for (int g = 0; g < pcs_pkg::NUM_GROUPS; g++) begin
      st_next.chk_ok[g] = (sums[g] == st_reg.checksum[g]);
    end

    // Events; a set in the cycle of its write-one-to-clear wins.
    events = 4'h0;
    events[pcs_pkg::EV_START]   = |(start_eff & ~st_reg.out.indication);
    events[pcs_pkg::EV_LIGHT]   = st_next.out.light_out & !st_reg.out.light_out;
    events[pcs_pkg::EV_CHK_BAD] = !(&st_reg.chk_ok);
    events[pcs_pkg::EV_CLEARED] = clear_req;
    st_next.irq_status = (st_reg.irq_status & ~w1c) | events;
    st_next.irq = |(st_next.irq_status & st_next.irq_mask);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg.mode      <= pcs_pkg::MODE_RST;
      st_reg.inhibit   <= pcs_pkg::INH_RST;
      st_reg.options   <= pcs_pkg::OPT_RST;
      st_reg.led_latch <= pcs_pkg::LED_RST;
      for (int g = 0; g < pcs_pkg::NUM_GROUPS; g++) begin
        st_reg.checksum[g] <= pcs_pkg::CHK_RST[g];
      end
      st_reg.irq_status <= 4'h0;
      st_reg.irq_mask   <= 4'h0;
      st_reg.sw_clear   <= 1'b0;
      st_reg.di_sync    <= 2'h0;
      st_reg.wr_pend    <= 1'b0;
      st_reg.rd_pend    <= 1'b0;
      st_reg.addr       <= 8'h00;
      st_reg.rdata      <= 32'h0000_0000;
      st_reg.ready      <= 1'b1;
      st_reg.resp       <= 1'b0;
      st_reg.irq        <= 1'b0;
      st_reg.chk_ok     <= 4'hF;
      st_reg.out        <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata    = st_reg.rdata;
  assign hreadyout = st_reg.ready;
  assign hresp     = st_reg.resp;
  assign prot_out  = st_reg.out;
  assign irq       = st_reg.irq;

endmodule : pcs_switchgroups

// ### verification/pcs_switchgroups_props.sv
// Port-level assertions for the protection configuration switch groups.
// Assumes one clock, synchronous reset, and hready looped back from hreadyout.
`timescale 1ns/1ps
module pcs_switchgroups_props (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      srst,
  // Register bus
  input wire logic                      hsel,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic                      hready,
  input wire logic                      hreadyout,
  // Protection side
  input wire pcs_pkg::pcs_prot_in_type  prot_in,
  input wire pcs_pkg::pcs_prot_out_type prot_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_read_wait: assert property (hsel && hready && htrans == 2'h2 && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("Read did not take one wait cycle.");
  a_light_cause: assert property (prot_out.light_out
    |-> $past(prot_in.light_request)) else $error("Light output without request.");
  a_ind_cause: assert property ($rose(prot_out.indication[0])
    |-> $past(prot_in.stage_start[0])) else $error("Indication rose without start.");
  a_ind_clear: assert property ((prot_in.front_panel_clear || prot_in.serial_clear)
    && !prot_in.stage_start[0] |=> !prot_out.indication[0]) else $error("Indication kept.");
  a_led_clear: assert property ((prot_in.front_panel_clear || prot_in.serial_clear)
    && !prot_in.led_signal[0] |=> !prot_out.programmable_indicator[0]) else $error("LED kept.");
  a_led_cause: assert property ($rose(prot_out.programmable_indicator[0])
    |-> $past(prot_in.led_signal[0])) else $error("LED lit without signal.");
  a_stage_inhibit: assert property (prot_out.stage_inhibit[1]
    && $past(prot_out.stage_inhibit[1]) && $past(prot_out.stage_inhibit[1], 2)
    |-> !$rose(prot_out.indication[2])) else $error("Inhibited stage started.");
  a_double_inrush: assert property (prot_out.double_high_oc || prot_out.double_high_ef
    |-> $past(prot_in.inrush)) else $error("Doubling without inrush.");
  a_block_oc_inv: assert property (prot_out.block_low_oc_inverse
    |-> $past(prot_in.stage_start[1] || prot_in.stage_start[2])) else $error("Bad oc block.");
  a_block_ef_inv: assert property (prot_out.block_low_ef_inverse
    |-> $past(prot_in.stage_start[4])) else $error("Bad earth-fault block.");
endmodule : pcs_switchgroups_props

bind pcs_switchgroups pcs_switchgroups_props i_props (.clk(clk), .srst(srst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .prot_in(prot_in), .prot_out(prot_out));

// ### verification/pcs_switchgroups_bench.sv
// Self-checking bench for the switch group block.
// Drives the AHB-Lite port and protection inputs itself; read data is checked from a queue.
`timescale 1ns/1ps
module pcs_switchgroups_bench;
  localparam logic [7:0] MSK [4] = '{8'h7F, 8'h7F, 8'h3F, 8'hFF};
  localparam logic [7:0] RST [4] = '{8'h00, 8'h78, 8'h00, 8'h00};
  localparam logic [7:0] L_INH [5] = '{8'h40, 8'h00, 8'h00, 8'h20, 8'h00};
  localparam logic [7:0] L_OPT [5] = '{8'h00, 8'h00, 8'h20, 8'h20, 8'h20};
  logic                      clk = 1'b0;
  logic                      srst = 1'b1;
  logic                      hsel = 1'b0;
  logic [31:0]               haddr = 32'h0;
  logic [1:0]                htrans = 2'h0;
  logic                      hwrite = 1'b0;
  logic [31:0]               hwdata = 32'h0;
  logic [31:0]               hrdata;
  logic                      hreadyout;
  logic                      hresp;
  logic                      irq;
  logic                      dclr = 1'b0;
  logic                      rd_dp = 1'b0;
  logic                      lt;
  logic [7:0]                v;
  pcs_pkg::pcs_prot_in_type  pin = '0;
  pcs_pkg::pcs_prot_out_type pout;
  logic [31:0]               exq [$];
  int                        fail_count = 0;
  int                        n_tests = 0;
  int                        cycles = 0;

  pcs_switchgroups i_dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .prot_in(pin), .digital_clear_pin(dclr),
    .prot_out(pout), .irq(irq));

  initial forever #20 clk = ~clk;

  task automatic check(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // Called just after a rising edge; hsel stays up so no signal is driven twice per step.
  task automatic bus(logic [7:0] a, logic w, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : bus

  task automatic rd(logic [7:0] a, logic [31:0] e);
    exq.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  // A group's checksum equals its value, as every switch weight is one bit.
  task automatic cfg(int i, logic [7:0] d);
    bus(8'(4 * i), 1'b1, {24'h0, d});
    bus(8'(16 + 4 * i), 1'b1, {24'h0, d & MSK[i]});
  endtask : cfg

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic now(logic [31:0] got_unused, logic [31:0] exp);
    @(negedge clk);
    check({26'h0, pout.stage_inhibit} & got_unused | {31'h0, irq} & ~got_unused, exp);
    @(posedge clk);
  endtask : now

  task automatic outs(logic [31:0] exp);
    @(negedge clk);
    check({28'h0, pout.double_high_oc, pout.double_high_ef, pout.block_low_oc_inverse,
      pout.block_low_ef_inverse}, exp);
    @(posedge clk);
  endtask : outs

  function automatic logic [31:0] st(logic [6:0] ind, logic [7:0] led, logic l);
    return {8'h0, 4'hF, 3'h0, l, led, 1'b0, ind};
  endfunction : st

  always @(posedge clk) begin
    cycles++;
    if (rd_dp && hreadyout) check(hrdata, exq.pop_front());
    if (rd_dp && hreadyout) check({31'h0, hresp}, 32'h0);
    if (hreadyout) rd_dp = hsel && htrans == 2'h2 && !hwrite;
    if (cycles == 5000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(71));
    cyc(8);
    srst <= 1'b0;
    cyc(2);
    now(32'hFFFF_FFFF, 32'h38);
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i), {24'h0, RST[i]});
      rd(8'(16 + 4 * i), {24'h0, RST[i]});
    end
    rd(8'h3C, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      cfg(i, v);
      rd(8'(4 * i), {24'h0, v & MSK[i]});
    end
    rd(8'h24, st(7'h0, 8'h0, 1'b0));
    // A seven-switch group never sums to 0x80, so this checksum always mismatches.
    bus(8'h10, 1'b1, 32'h80);
    rd(8'h24, st(7'h0, 8'h0, 1'b0) ^ 32'h0010_0000);
    // Interrupt: clear, raise a start event while masked, unmask, clear again.
    cfg(0, 8'h00);
    bus(8'h28, 1'b1, 32'hF);
    rd(8'h28, 32'h0);
    pin.stage_start <= 7'h01;
    cyc(2);
    pin.stage_start <= 7'h00;
    now(32'h0, 32'h0);
    bus(8'h2C, 1'b1, 32'h1);
    now(32'h0, 32'h1);
    bus(8'h28, 1'b1, 32'h1);
    now(32'h0, 32'h0);
    // Latched stages 0 and 1, inhibited stage 2, LED latches on 0xA5.
    cfg(0, 8'h03);
    cfg(1, 8'h02);
    cfg(2, 8'h00);
    cfg(3, 8'hA5);
    pin.stage_phase[0] <= 3'h5;
    pin.stage_start <= 7'h07;
    pin.led_signal <= 8'hFF;
    cyc(2);
    pin.stage_phase[0] <= 3'h0;
    pin.stage_start <= 7'h10;
    pin.led_signal <= 8'h02;
    cyc(2);
    rd(8'h24, st(7'h13, 8'hA7, 1'b0));
    rd(8'h30, 32'h5);
    pin.stage_start <= 7'h00;
    pin.led_signal <= 8'h00;
    cyc(2);
    rd(8'h24, st(7'h03, 8'hA5, 1'b0));
    for (int k = 0; k < 4; k++) begin
      pin.stage_start <= 7'h03;
      pin.led_signal <= 8'hFF;
      cyc(2);
      pin.stage_start <= 7'h00;
      pin.led_signal <= 8'h00;
      cyc(1);
      pin.front_panel_clear <= (k == 0);
      pin.serial_clear <= (k == 1);
      dclr <= (k == 2);
      cyc(2);
      if (k == 3) bus(8'h20, 1'b1, 32'h1);
      pin.front_panel_clear <= 1'b0;
      pin.serial_clear <= 1'b0;
      dclr <= 1'b0;
      cyc(5);
      rd(8'h24, st(7'h00, 8'h00, 1'b0));
      rd(8'h30, 32'h0);
    end
    // Start, checksum mismatch and clear events have all been seen; no light yet.
    rd(8'h28, 32'hD);
    // Light output against its inhibit, the arc block option and the arc inhibit.
    pin.light_request <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      cfg(1, L_INH[k]);
      cfg(2, L_OPT[k]);
      pin.arc_trip <= (k == 2 || k == 3);
      cyc(2);
      lt = !L_INH[k][6] && !(L_OPT[k][5] && (k == 2 || k == 3) && !L_INH[k][5]);
      rd(8'h24, st(7'h00, 8'h00, lt));
    end
    pin.light_request <= 1'b0;
    pin.arc_trip <= 1'b0;
    cfg(0, 8'h00);
    cfg(1, 8'h00);
    cfg(2, 8'h1B);
    pin.inrush <= 1'b1;
    pin.stage_start <= 7'h12;
    cyc(2);
    outs(32'hF);
    cfg(2, 8'h04);
    pin.stage_start <= 7'h04;
    cyc(2);
    outs(32'h2);
    pin.stage_start <= 7'h00;
    pin.inrush <= 1'b0;
    cyc(4);
    end_of_test();
  end
endmodule : pcs_switchgroups_bench
